/* common/pct_cfg.svh */
// offsets, fields, reset values and timing counts of the position compare core
// What this block does
// - each fifo comparator is 32 bits and reloads from its own point fifo
// - fifo comparator source selects any of four counters or two timers
// - next point loads only after the current one matched and fired
// - position is a 32-bit binary up/down counter
// - quadrature mode counts one, two or four edges per cycle
// - dual-pulse mode: phase a pulses count up, phase b pulses down
// - dual-pulse idle level selectable high or low, counting the leaving edge
// - quadrature counts up when phase a leads phase b, down when lagging
// - selected index edge, rising or falling, clears the counter to zero
// - pulse width 0.2us to 6.55ms, pulse rate up to 1 MHz
// - linear generator adds a fixed increment to the point on every match
// - two independent linear generators, each comparing with counter 0 or 1
// - two fifos of 15 points, each routable to any of four channels
// - fifo and linear comparators are separate and run concurrently
// - toggle mode inverts the channel output on every match
// - mapping lets any source drive many outputs and many drive one
// - match only on exact equality, and a match fires the trigger
// - index or origin activity captures the counter into a readable latch
// - a general digital input captures a counter value for later reading
// - timer counts down, at zero pulses a trigger or increments a counter
// - timer ticks every 100ns, 30-bit reload, 100ns to about 107s intervals
`ifndef PCT_CFG_SVH
`define PCT_CFG_SVH
`define PCT_CLK_NS       50
`define PCT_TICK_NS      100
`define PCT_TICK_CYC     ((`PCT_TICK_NS + `PCT_CLK_NS - 1) / `PCT_CLK_NS)
`define PCT_PW_MIN       16'h0002
`define PCT_A_CNT_CFG    6'h00
`define PCT_A_CNT_VAL    6'h04
`define PCT_A_IDX_LAT    6'h08
`define PCT_A_ORIG_LAT   6'h0C
`define PCT_A_GPI_LAT    6'h0D
`define PCT_A_LAT_SEL    6'h0E
`define PCT_A_FIFO       6'h10
`define PCT_A_FIFO_SRC   6'h12
`define PCT_A_LIN_START  6'h14
`define PCT_A_LIN_INC    6'h16
`define PCT_A_LIN_CFG    6'h18
`define PCT_A_MAP        6'h1A
`define PCT_A_PW_CFG     6'h1C
`define PCT_A_TMR_RLD    6'h20
`define PCT_A_TMR_EN     6'h22
`define PCT_A_STATUS     6'h23
`define PCT_F_MODE       1:0
`define PCT_F_IDLE_HI    2
`define PCT_F_IDX_FALL   3
`define PCT_F_IDX_CLR    4
`define PCT_F_TMR_INC    5
`define PCT_F_TMR_SEL    6
`define PCT_F_TOGGLE     16
`endif

/* common/pct_pkg.sv */
// types of the position compare core
package pct_pkg;
   typedef enum logic [1:0] {
      PCT_X1,
      PCT_X2,
      PCT_X4,
      PCT_DUAL
   } pct_mode_t;
   typedef logic [31:0] pct_word_t;
endpackage

/* core/pct_top.sv */
// position compare and trigger core
`timescale 1ns/1ps
`include "pct_cfg.svh"
module pct_top
   import pct_pkg::*;
#(
   parameter int FIFO_DEPTH = 15
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [31:0] reg_rdata,
   input  wire logic [3:0]  enc_phase_a,
   input  wire logic [3:0]  enc_phase_b,
   input  wire logic [3:0]  enc_index,
   input  wire logic        origin_input,
   input  wire logic        gpi_latch_in,
   output logic      [3:0]  trigger_out
);
   localparam int FAW = $clog2(FIFO_DEPTH + 1);
   localparam logic [FAW-1:0] FLAST = FAW'(FIFO_DEPTH - 1);
   localparam logic [FAW-1:0] FFULL = FAW'(FIFO_DEPTH);

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [13:0] sy1_q;
   logic [13:0] sy2_q;
   logic [13:0] sy3_q;
   logic [13:0] sy_raw;
   assign sy_raw = {gpi_latch_in, origin_input, enc_index, enc_phase_b, enc_phase_a};
   always_ff @(posedge clk) begin
      if (srst) begin
         sy1_q <= 14'h0000;
         sy2_q <= 14'h0000;
         sy3_q <= 14'h0000;
      end else begin
         sy1_q <= sy_raw;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
      end
   end
   logic orig_rise;
   logic gpi_rise;
   assign orig_rise = sy2_q[12] & ~sy3_q[12];
   assign gpi_rise = sy2_q[13] & ~sy3_q[13];

   // ************************************************
   // configuration registers
   // ************************************************
   logic [6:0]  ccfg_q [4];
   logic [6:0]  ccfg_d [4];
   logic [3:0]  lsel_q;
   logic [3:0]  lsel_d;
   logic [2:0]  fsrc_q [2];
   logic [2:0]  fsrc_d [2];
   logic [31:0] linc_q [2];
   logic [31:0] linc_d [2];
   logic [1:0]  lcfg_q [2];
   logic [1:0]  lcfg_d [2];
   logic [23:0] map_q;
   logic [23:0] map_d;
   logic [16:0] pw_q   [4];
   logic [16:0] pw_d   [4];
   logic [29:0] trld_q [2];
   logic [29:0] trld_d [2];
   logic [1:0]  ten_q;
   logic [1:0]  ten_d;

   always_comb begin
      ccfg_d = ccfg_q;
      lsel_d = lsel_q;
      fsrc_d = fsrc_q;
      linc_d = linc_q;
      lcfg_d = lcfg_q;
      map_d  = map_q;
      pw_d   = pw_q;
      trld_d = trld_q;
      ten_d  = ten_q;
      if (reg_we) begin
         for (int k = 0; k < 4; k++) begin
            if (reg_addr == 6'(`PCT_A_CNT_CFG + k)) begin
               ccfg_d[k] = reg_wdata[6:0];
            end
            if (reg_addr == 6'(`PCT_A_PW_CFG + k)) begin
               pw_d[k] = reg_wdata[16:0];
            end
         end
         for (int k = 0; k < 2; k++) begin
            if (reg_addr == 6'(`PCT_A_FIFO_SRC + k)) begin
               fsrc_d[k] = reg_wdata[2:0];
            end
            if (reg_addr == 6'(`PCT_A_LIN_INC + k)) begin
               linc_d[k] = reg_wdata;
            end
            if (reg_addr == 6'(`PCT_A_LIN_CFG + k)) begin
               lcfg_d[k] = reg_wdata[1:0];
            end
            if (reg_addr == 6'(`PCT_A_TMR_RLD + k)) begin
               trld_d[k] = reg_wdata[29:0];
            end
         end
         if (reg_addr == `PCT_A_LAT_SEL) begin
            lsel_d = reg_wdata[3:0];
         end
         if (reg_addr == `PCT_A_MAP) begin
            map_d = reg_wdata[23:0];
         end
         if (reg_addr == `PCT_A_TMR_EN) begin
            ten_d = reg_wdata[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int k = 0; k < 4; k++) begin
            ccfg_q[k] <= 7'h00;
            pw_q[k]   <= {1'b0, `PCT_PW_MIN};
         end
         for (int k = 0; k < 2; k++) begin
            fsrc_q[k] <= 3'h0;
            linc_q[k] <= 32'h0000_0000;
            lcfg_q[k] <= 2'h0;
            trld_q[k] <= 30'h0000_0000;
         end
         lsel_q <= 4'h0;
         map_q  <= 24'h00_0000;
         ten_q  <= 2'h0;
      end else begin
         ccfg_q <= ccfg_d;
         lsel_q <= lsel_d;
         fsrc_q <= fsrc_d;
         linc_q <= linc_d;
         lcfg_q <= lcfg_d;
         map_q  <= map_d;
         pw_q   <= pw_d;
         trld_q <= trld_d;
         ten_q  <= ten_d;
      end
   end

   // ************************************************
   // timers
   // ************************************************
   logic [7:0]  tick_q;
   logic [7:0]  tick_d;
   logic        tick;
   logic [29:0] tval_q [2];
   logic [1:0]  tfire;
   assign tick = (tick_q == 8'(`PCT_TICK_CYC - 1));
   always_comb begin
      tick_d = tick ? 8'h00 : tick_q + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         tick_q <= 8'h00;
      end else begin
         tick_q <= tick_d;
      end
   end

   for (genvar j = 0; j < 2; j++) begin : g_tmr
      logic [29:0] tval_d;
      always_comb begin
         tval_d   = tval_q[j];
         tfire[j] = 1'b0;
         if (!ten_q[j]) begin
            tval_d = trld_q[j];
         end else if (tick) begin
            if (tval_q[j] <= 30'h0000_0001) begin
               tfire[j] = 1'b1;
               tval_d   = trld_q[j];
            end else begin
               tval_d = tval_q[j] - 30'h0000_0001;
            end
         end
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            tval_q[j] <= 30'h0000_0000;
         end else begin
            tval_q[j] <= tval_d;
         end
      end
   end

   // ************************************************
   // encoder counters and index latches
   // ************************************************
   pct_word_t cnt_q [4];
   pct_word_t ilat_q [4];

   for (genvar i = 0; i < 4; i++) begin : g_cnt
      pct_word_t cnt_d;
      pct_word_t ilat_d;
      pct_mode_t mode;
      logic      ac, ap, bc, bp, ic, ip;
      logic      ae, be, up, dn, tinc, idx_hit, idle;
      assign ac   = sy2_q[i];
      assign ap   = sy3_q[i];
      assign bc   = sy2_q[4+i];
      assign bp   = sy3_q[4+i];
      assign ic   = sy2_q[8+i];
      assign ip   = sy3_q[8+i];
      assign mode = pct_mode_t'(ccfg_q[i][`PCT_F_MODE]);
      assign idle = ccfg_q[i][`PCT_F_IDLE_HI];
      always_comb begin
         ae = ac ^ ap;
         be = bc ^ bp;
         up = 1'b0;
         dn = 1'b0;
         case (mode)
            PCT_X1: begin
               up = ae & ac & ~bc;
               dn = ae & ac & bc;
            end
            PCT_X2: begin
               up = ae & (ac ^ bc);
               dn = ae & ~(ac ^ bc);
            end
            PCT_X4: begin
               up = (ae ^ be) & (ac ^ bp);
               dn = (ae ^ be) & ~(ac ^ bp);
            end
            PCT_DUAL: begin
               up = ae & (ac ^ idle);
               dn = be & (bc ^ idle);
            end
            default: begin
               up = 1'b0;
               dn = 1'b0;
            end
         endcase
         tinc    = ccfg_q[i][`PCT_F_TMR_INC] & tfire[ccfg_q[i][`PCT_F_TMR_SEL]];
         idx_hit = (ic ^ ip) & (ic ^ ccfg_q[i][`PCT_F_IDX_FALL]);
         cnt_d   = cnt_q[i] + 32'(up) + 32'(tinc) - 32'(dn);
         if (idx_hit && ccfg_q[i][`PCT_F_IDX_CLR]) begin
            cnt_d = 32'h0000_0000;
         end
         ilat_d = idx_hit ? cnt_q[i] : ilat_q[i];
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            cnt_q[i]  <= 32'h0000_0000;
            ilat_q[i] <= 32'h0000_0000;
         end else begin
            cnt_q[i]  <= cnt_d;
            ilat_q[i] <= ilat_d;
         end
      end
   end

   // origin and general input latches
   pct_word_t olat_q, olat_d, glat_q, glat_d;
   always_comb begin
      olat_d = orig_rise ? cnt_q[lsel_q[1:0]] : olat_q;
      glat_d = gpi_rise ? cnt_q[lsel_q[3:2]] : glat_q;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         olat_q <= 32'h0000_0000;
         glat_q <= 32'h0000_0000;
      end else begin
         olat_q <= olat_d;
         glat_q <= glat_d;
      end
   end

   // ************************************************
   // comparison sources
   // ************************************************
   pct_word_t src [8];
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         src[k] = cnt_q[k];
      end
      src[4] = {2'b00, tval_q[0]};
      src[5] = {2'b00, tval_q[1]};
      src[6] = 32'h0000_0000;
      src[7] = 32'h0000_0000;
   end

   // ************************************************
   // fifo comparators
   // ************************************************
   logic [1:0]     fmatch;
   logic [1:0]     fval_q;
   logic [FAW-1:0] fcnt_q [2];

   for (genvar f = 0; f < 2; f++) begin : g_fifo
      pct_word_t      mem [FIFO_DEPTH];
      pct_word_t      pt_q, pt_d;
      logic [FAW-1:0] wp_q, wp_d, rp_q, rp_d, fcnt_d;
      logic           push, pop, fval_d;
      // full fifo drops the write: software reads the fill level first
      assign push = reg_we && (reg_addr == 6'(`PCT_A_FIFO + f)) && (fcnt_q[f] != FFULL);
      always_comb begin
         fmatch[f] = fval_q[f] && (src[fsrc_q[f]] == pt_q);
         pop    = !fval_q[f] && (fcnt_q[f] != '0);
         pt_d   = pop ? mem[rp_q] : pt_q;
         fval_d = pop | (fval_q[f] & ~fmatch[f]);
         wp_d   = push ? ((wp_q == FLAST) ? '0 : wp_q + FAW'(1)) : wp_q;
         rp_d   = pop ? ((rp_q == FLAST) ? '0 : rp_q + FAW'(1)) : rp_q;
         fcnt_d = fcnt_q[f] + FAW'(push) - FAW'(pop);
      end
      always_ff @(posedge clk) begin
         if (push) begin
            mem[wp_q] <= reg_wdata;
         end
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            pt_q      <= 32'h0000_0000;
            fval_q[f] <= 1'b0;
            wp_q      <= '0;
            rp_q      <= '0;
            fcnt_q[f] <= '0;
         end else begin
            pt_q      <= pt_d;
            fval_q[f] <= fval_d;
            wp_q      <= wp_d;
            rp_q      <= rp_d;
            fcnt_q[f] <= fcnt_d;
         end
      end
   end

   // ************************************************
   // linear function comparators
   // ************************************************
   logic [1:0] lmatch;
   logic [1:0] lval_q;
   for (genvar l = 0; l < 2; l++) begin : g_lin
      pct_word_t lpt_q, lpt_d;
      logic      lval_d, ld;
      assign ld = reg_we && (reg_addr == 6'(`PCT_A_LIN_START + l));
      always_comb begin
         lmatch[l] = lcfg_q[l][1] && lval_q[l] && (cnt_q[lcfg_q[l][0]] == lpt_q);
         lpt_d  = ld ? reg_wdata : (lmatch[l] ? lpt_q + linc_q[l] : lpt_q);
         lval_d = ld | lval_q[l];
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            lpt_q     <= 32'h0000_0000;
            lval_q[l] <= 1'b0;
         end else begin
            lpt_q     <= lpt_d;
            lval_q[l] <= lval_d;
         end
      end
   end

   // ************************************************
   // mapping and pulse shaping
   // ************************************************
   logic [5:0] ev;
   assign ev = {tfire, lmatch, fmatch};

   for (genvar c = 0; c < 4; c++) begin : g_pw
      logic [16:0] pc_q, pc_d;
      logic [15:0] w;
      logic        lvl_q, lvl_d, out_d, hit;
      always_comb begin
         hit   = |(map_q[c*6 +: 6] & ev);
         lvl_d = lvl_q ^ hit;
         w     = (pw_q[c][15:0] < `PCT_PW_MIN) ? `PCT_PW_MIN : pw_q[c][15:0];
         if (hit) begin
            pc_d = 17'(w * `PCT_TICK_CYC);
         end else if (pc_q != 17'h0_0000) begin
            pc_d = pc_q - 17'h0_0001;
         end else begin
            pc_d = pc_q;
         end
         out_d = pw_q[c][`PCT_F_TOGGLE] ? lvl_d : (pc_d != 17'h0_0000);
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            pc_q           <= 17'h0_0000;
            lvl_q          <= 1'b0;
            trigger_out[c] <= 1'b0;
         end else begin
            pc_q           <= pc_d;
            lvl_q          <= lvl_d;
            trigger_out[c] <= out_d;
         end
      end
   end

   // ************************************************
   // register read port
   // ************************************************
   pct_word_t rd_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      if (reg_re) begin
         for (int k = 0; k < 4; k++) begin
            if (reg_addr == 6'(`PCT_A_CNT_CFG + k)) begin
               rd_d = {25'h000_0000, ccfg_q[k]};
            end
            if (reg_addr == 6'(`PCT_A_CNT_VAL + k)) begin
               rd_d = cnt_q[k];
            end
            if (reg_addr == 6'(`PCT_A_IDX_LAT + k)) begin
               rd_d = ilat_q[k];
            end
            if (reg_addr == 6'(`PCT_A_PW_CFG + k)) begin
               rd_d = {15'h0000, pw_q[k]};
            end
         end
         for (int k = 0; k < 2; k++) begin
            if (reg_addr == 6'(`PCT_A_FIFO + k)) begin
               rd_d = 32'(fcnt_q[k]);
            end
            if (reg_addr == 6'(`PCT_A_FIFO_SRC + k)) begin
               rd_d = {29'h0000_0000, fsrc_q[k]};
            end
            if (reg_addr == 6'(`PCT_A_LIN_INC + k)) begin
               rd_d = linc_q[k];
            end
            if (reg_addr == 6'(`PCT_A_LIN_CFG + k)) begin
               rd_d = {30'h0000_0000, lcfg_q[k]};
            end
            if (reg_addr == 6'(`PCT_A_TMR_RLD + k)) begin
               rd_d = {2'b00, trld_q[k]};
            end
         end
         case (reg_addr)
            `PCT_A_ORIG_LAT: rd_d = olat_q;
            `PCT_A_GPI_LAT: rd_d = glat_q;
            `PCT_A_LAT_SEL: rd_d = {28'h000_0000, lsel_q};
            `PCT_A_MAP:     rd_d = {8'h00, map_q};
            `PCT_A_TMR_EN:  rd_d = {30'h0000_0000, ten_q};
            `PCT_A_STATUS:  rd_d = {24'h00_0000, lval_q, fval_q, trigger_out};
            default:        rd_d = rd_d;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= rd_d;
      end
   end
endmodule

/* test/pct_properties.sv */
// port checker of the position compare core and its bind
`timescale 1ns/1ps
module pct_properties
   import pct_pkg::*;
#(
   parameter int FIFO_DEPTH = 15
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [5:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_we,
   input wire logic        reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic [3:0]  trigger_out
);
   logic [15:0] w0_q;
   logic [15:0] w0_d;
   logic        tg0_q;
   logic        tg0_d;
   logic [17:0] hi_q;
   logic [17:0] hi_d;
   logic [17:0] min_hi;
   // **********
   // shadow of channel 0 shaping; a retrigger only lengthens, so a floor is checked
   // **********
   always_comb begin
      w0_d = w0_q;
      tg0_d = tg0_q;
      if (reg_we && reg_addr == 6'h1C) begin
         w0_d = reg_wdata[15:0];
         tg0_d = reg_wdata[16];
      end
      hi_d = trigger_out[0] ? hi_q + 18'h1 : 18'h0;
      min_hi = (w0_q < 16'h0002) ? 18'h4 : {1'b0, w0_q, 1'b0};
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         w0_q <= 16'h0002;
         tg0_q <= 1'b0;
         hi_q <= 18'h0;
      end else begin
         w0_q <= w0_d;
         tg0_q <= tg0_d;
         hi_q <= hi_d;
      end
   end
   // **********
   // properties
   // **********
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_rd(a);
      reg_re && reg_addr == a;
   endsequence
   sequence s_rd2(a);
      reg_re && reg_addr[5:1] == a;
   endsequence
   sequence s_pulse_end;
      $fell(trigger_out[0]) && !tg0_q;
   endsequence
   property p_rst_quiet;
      $fell(srst) |-> trigger_out == 4'h0 && reg_rdata == 32'h0000_0000;
   endproperty
   property p_rd_idle;
      !$past(reg_re) |-> reg_rdata == 32'h0000_0000;
   endproperty
   property p_unmapped;
      reg_re && reg_addr >= 6'h24 |=> reg_rdata == 32'h0000_0000;
   endproperty
   property p_fifo_lvl;
      s_rd2(5'h08) |=> reg_rdata <= FIFO_DEPTH;
   endproperty
   property p_src_3b;
      s_rd2(5'h09) |=> reg_rdata[31:3] == 29'h0000_0000;
   endproperty
   property p_tmr_30;
      s_rd2(5'h10) |=> reg_rdata[31:30] == 2'h0;
   endproperty
   property p_status;
      s_rd(6'h23) |=> reg_rdata[3:0] == $past(trigger_out) && reg_rdata[31:8] == 24'h00_0000;
   endproperty
   property p_pulse_min;
      s_pulse_end |-> hi_q >= min_hi;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_fifo_lvl: assert property (p_fifo_lvl) else $error("fifo level above depth");
   a_src_3b: assert property (p_src_3b) else $error("source field too wide");
   a_tmr_30: assert property (p_tmr_30) else $error("reload wider than 30 bits");
   a_status: assert property (p_status) else $error("status differs from outputs");
   a_pulse_min: assert property (p_pulse_min) else $error("trigger pulse too short");
endmodule
bind pct_top pct_properties #(.FIFO_DEPTH(FIFO_DEPTH)) pct_properties_inst (
   .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
   .reg_re(reg_re), .reg_rdata(reg_rdata), .trigger_out(trigger_out)
);

/* test/pct_enc.sv */
// far-side encoders, index marks and latch inputs
`timescale 1ns/1ps
module pct_enc
   import pct_pkg::*;
(
   input  wire logic  clk,
   output logic [3:0] enc_phase_a,
   output logic [3:0] enc_phase_b,
   output logic [3:0] enc_index,
   output logic       origin_input,
   output logic       gpi_latch_in
);
   // raised for slow equipment; each level must stay at least two cycles
   int hold_cyc = 3;
   initial begin
      enc_phase_a = 4'h0;
      enc_phase_b = 4'h0;
      enc_index = 4'h0;
      origin_input = 1'b0;
      gpi_latch_in = 1'b0;
   end
   task automatic set_pin(input int sel, input int ch, input logic v);
      @(posedge clk);
      case (sel)
         0: enc_phase_a[ch] <= v;
         1: enc_phase_b[ch] <= v;
         2: enc_index[ch] <= v;
         3: origin_input <= v;
         default: gpi_latch_in <= v;
      endcase
      repeat (hold_cyc) @(posedge clk);
   endtask
   task automatic pulse(input int sel, input int ch, input logic idle);
      set_pin(sel, ch, ~idle);
      set_pin(sel, ch, idle);
   endtask
   // gray steps: a leads b when counting up
   task automatic quad(input int ch, input bit up, input int n);
      for (int i = 0; i < n; i++) begin
         if (up ^ enc_phase_a[ch] ^ enc_phase_b[ch]) begin
            set_pin(0, ch, ~enc_phase_a[ch]);
         end else begin
            set_pin(1, ch, ~enc_phase_b[ch]);
         end
      end
      repeat (4) @(posedge clk);
   endtask
endmodule

/* test/position_compare_trigger_bench.sv */
// self-checking bench of the position compare core
`timescale 1ns/1ps
module position_compare_trigger_bench;
   import pct_pkg::*;
   logic        clk;
   logic        srst;
   logic [5:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_we;
   logic        reg_re;
   logic [31:0] reg_rdata;
   logic [3:0]  enc_phase_a;
   logic [3:0]  enc_phase_b;
   logic [3:0]  enc_index;
   logic        origin_input;
   logic        gpi_latch_in;
   logic [3:0]  trigger_out;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cur [4] = '{default: 0};
   int          len [4] = '{default: 0};
   int          rise [4] = '{default: 0};
   pct_top pct_top_inst (
      .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .enc_phase_a(enc_phase_a),
      .enc_phase_b(enc_phase_b), .enc_index(enc_index), .origin_input(origin_input),
      .gpi_latch_in(gpi_latch_in), .trigger_out(trigger_out)
   );
   pct_enc pct_enc_inst (
      .clk(clk), .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b),
      .enc_index(enc_index), .origin_input(origin_input), .gpi_latch_in(gpi_latch_in)
   );
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // sampled on the falling edge so bench tasks never race the outputs
   always @(negedge clk) begin
      for (int c = 0; c < 4; c++) begin
         if (trigger_out[c] === 1'b1) begin
            if (cur[c] == 0) rise[c]++;
            cur[c]++;
         end else begin
            if (cur[c] != 0) len[c] = cur[c];
            cur[c] = 0;
         end
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic t_reset();
      rc(6'h04, 32'h0000_0000);
      rc(6'h1C, 32'h0000_0002);
      rc(6'h10, 32'h0000_0000);
      rc(6'h23, 32'h0000_0000);
      wr(6'h30, 32'h0000_00FF);
      rc(6'h30, 32'h0000_0000);
      wr(6'h20, 32'h0000_0003);
      rc(6'h20, 32'h0000_0003);
   endtask
   task automatic t_modes();
      wr(6'h00, 32'h0000_0002);
      wr(6'h01, 32'h0000_0001);
      wr(6'h02, 32'h0000_0000);
      for (int c = 0; c < 3; c++) begin
         pct_enc_inst.quad(c, 1'b1, 4);
      end
      rc(6'h04, 32'h0000_0004);
      rc(6'h05, 32'h0000_0002);
      rc(6'h06, 32'h0000_0001);
      pct_enc_inst.quad(0, 1'b0, 2);
      rc(6'h04, 32'h0000_0002);
      pct_enc_inst.hold_cyc = 6;
      pct_enc_inst.quad(2, 1'b0, 8);
      pct_enc_inst.hold_cyc = 3;
      rc(6'h06, 32'hFFFF_FFFF);
   endtask
   task automatic t_dual();
      wr(6'h03, 32'h0000_0003);
      for (int i = 0; i < 3; i++) begin
         pct_enc_inst.pulse(0, 3, 1'b0);
      end
      pct_enc_inst.pulse(1, 3, 1'b0);
      rc(6'h07, 32'h0000_0002);
      wr(6'h03, 32'h0000_0007);
      pct_enc_inst.set_pin(0, 3, 1'b1);
      pct_enc_inst.set_pin(1, 3, 1'b1);
      rc(6'h07, 32'h0000_0002);
      pct_enc_inst.pulse(0, 3, 1'b1);
      pct_enc_inst.pulse(0, 3, 1'b1);
      rc(6'h07, 32'h0000_0004);
   endtask
   task automatic t_index();
      wr(6'h00, 32'h0000_001A);
      pct_enc_inst.set_pin(2, 0, 1'b1);
      rc(6'h04, 32'h0000_0002);
      pct_enc_inst.set_pin(2, 0, 1'b0);
      rc(6'h04, 32'h0000_0000);
      rc(6'h08, 32'h0000_0002);
      wr(6'h00, 32'h0000_0012);
      pct_enc_inst.quad(0, 1'b1, 3);
      pct_enc_inst.pulse(2, 0, 1'b0);
      rc(6'h04, 32'h0000_0000);
      rc(6'h08, 32'h0000_0003);
      wr(6'h00, 32'h0000_0002);
      wr(6'h0E, 32'h0000_000D);
      pct_enc_inst.pulse(3, 0, 1'b0);
      pct_enc_inst.pulse(4, 0, 1'b0);
      rc(6'h0C, 32'h0000_0002);
      rc(6'h0D, 32'h0000_0004);
   endtask
   task automatic t_fifo();
      wr(6'h12, 32'h0000_0000);
      wr(6'h1A, 32'h0000_0001);
      wr(6'h1C, 32'h0000_0003);
      wr(6'h10, 32'h0000_0002);
      wr(6'h10, 32'h0000_0004);
      rc(6'h10, 32'h0000_0001);
      rc(6'h12, 32'h0000_0000);
      pct_enc_inst.quad(0, 1'b1, 1);
      check(rise[0], 0);
      pct_enc_inst.quad(0, 1'b1, 1);
      repeat (10) @(posedge clk);
      check(rise[0], 1);
      check(len[0], 6);
      rc(6'h10, 32'h0000_0000);
      pct_enc_inst.quad(0, 1'b1, 2);
      repeat (10) @(posedge clk);
      check(rise[0], 2);
      for (int i = 0; i < 17; i++) begin
         wr(6'h10, 32'h0000_0100 + i);
      end
      rc(6'h10, 32'h0000_000F);
   endtask
   task automatic t_linear();
      wr(6'h16, 32'h0000_0003);
      wr(6'h17, 32'h0000_0001);
      wr(6'h1D, 32'h0001_0000);
      wr(6'h1A, 32'h0000_C101);
      wr(6'h18, 32'h0000_0002);
      wr(6'h14, 32'h0000_0005);
      wr(6'h19, 32'h0000_0003);
      wr(6'h15, 32'h0000_0003);
      pct_enc_inst.quad(0, 1'b1, 1);
      pct_enc_inst.quad(1, 1'b1, 1);
      repeat (6) @(posedge clk);
      check({28'h000_0000, trigger_out}, 32'h0000_0002);
      check(rise[2], 2);
      pct_enc_inst.quad(0, 1'b1, 3);
      repeat (6) @(posedge clk);
      check({28'h000_0000, trigger_out}, 32'h0000_0000);
      check(rise[2], 3);
   endtask
   task automatic t_timer();
      int r0;
      wr(6'h1A, 32'h0040_0002);
      wr(6'h13, 32'h0000_0004);
      wr(6'h11, 32'h0000_0002);
      wr(6'h02, 32'h0000_0020);
      wr(6'h22, 32'h0000_0001);
      repeat (20) @(posedge clk);
      r0 = rise[3];
      repeat (60) @(posedge clk);
      check(rise[3] - r0, 10);
      wr(6'h22, 32'h0000_0000);
      repeat (10) @(posedge clk);
      rc(6'h06, 32'hFFFF_FFFF + rise[3]);
      check(rise[0], 3);
   endtask
   initial begin
      srst = 1'b1;
      reg_addr = 6'h00;
      reg_wdata = 32'h0000_0000;
      reg_we = 1'b0;
      reg_re = 1'b0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_modes();
      t_dual();
      t_index();
      t_fifo();
      t_linear();
      t_timer();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule
